//--- rtl/csfl_core.sv
`timescale 1ns/1ps
module csfl_core #(
    parameter logic [15:0] GPR_BASE = 16'h0100,
    parameter logic [15:0] IO_TOP = 16'h007F,
    parameter logic [15:0] DATA_TOP = 16'h7FFF,
    parameter logic [15:0] VEC_BASE = 16'hFFC0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire csfl_pkg::csfl_axi_req_s axi_req,
    output csfl_pkg::csfl_axi_rsp_s axi_rsp,
    input wire logic irq_req,
    input wire logic [1:0] irq_level,
    output logic irq_accept,
    output logic [15:0] psw,
    output logic [15:0] gpr_addr,
    output logic [1:0] pc_region
);

    // ==========================================================
    // State
    csfl_pkg::csfl_axi_rsp_s rsp_q, rsp_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic wr_fire, exec, wide;
    logic [15:0] pc_q, acc_q, tmp_q, idx_q, ext_q, stk_q, psw_q;
    logic [15:0] acc_d;
    logic [7:0] ccr_d;
    logic [2:0] gsel_q;
    logic [15:0] gpr_addr_q;
    logic [1:0] pc_region_q;
    logic irq_accept_q;
    csfl_pkg::csfl_op_e op;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic [1:0] region_of(input logic [15:0] a);
        if (a <= IO_TOP) begin
            region_of = csfl_pkg::REGION_IO;
        end else if (a <= DATA_TOP) begin
            region_of = csfl_pkg::REGION_DATA;
        end else if (a >= VEC_BASE) begin
            region_of = csfl_pkg::REGION_VEC;
        end else begin
            region_of = csfl_pkg::REGION_PROG;
        end
    endfunction : region_of

    function automatic logic [33:0] read_reg(input logic [7:0] a, input logic [15:0] pc,
                                             input logic [15:0] ac, input logic [15:0] tm,
                                             input logic [15:0] ix, input logic [15:0] ep,
                                             input logic [15:0] sp, input logic [15:0] ps,
                                             input logic [7:0] st, input logic [15:0] ga);
        read_reg = {csfl_pkg::RESP_OKAY, 32'h0000_0000};
        unique case (a)
            csfl_pkg::OFF_PC: read_reg[15:0] = pc;
            csfl_pkg::OFF_ACC: read_reg[15:0] = ac;
            csfl_pkg::OFF_TMP: read_reg[15:0] = tm;
            csfl_pkg::OFF_IDX: read_reg[15:0] = ix;
            csfl_pkg::OFF_EXT: read_reg[15:0] = ep;
            csfl_pkg::OFF_STK: read_reg[15:0] = sp;
            csfl_pkg::OFF_PSW: read_reg[15:0] = ps;
            csfl_pkg::OFF_OP: read_reg[15:0] = 16'h0000;
            csfl_pkg::OFF_STAT: read_reg[7:0] = st;
            csfl_pkg::OFF_GSEL: read_reg[15:0] = ga;
            default: read_reg[33:32] = csfl_pkg::RESP_SLVERR;
        endcase
    endfunction : read_reg

    // ==========================================================
    // AXI4-Lite slave
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        rsp_d = rsp_q;
        if (axi_req.awvalid && rsp_q.awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && rsp_q.wready) begin
            w_have_d = 1'b1;
            w_data_d = axi_req.wdata;
            w_strb_d = axi_req.wstrb;
        end
        if (rsp_q.bvalid && axi_req.bready) begin
            rsp_d.bvalid = 1'b0;
        end
        wr_fire = aw_have_d && w_have_d && !rsp_q.bvalid;
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp = (aw_addr_d > csfl_pkg::OFF_GSEL || aw_addr_d[1:0] != 2'h0) ?
                          csfl_pkg::RESP_SLVERR : csfl_pkg::RESP_OKAY;
        end
        rsp_d.awready = !aw_have_d && !rsp_d.bvalid;
        rsp_d.wready = !w_have_d && !rsp_d.bvalid;
        if (rsp_q.rvalid && axi_req.rready) begin
            rsp_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && rsp_q.arready) begin
            rsp_d.rvalid = 1'b1;
            {rsp_d.rresp, rsp_d.rdata} = read_reg(axi_req.araddr, pc_q, acc_q, tmp_q,
                                                  idx_q, ext_q, stk_q, psw_q,
                                                  {3'h0, irq_accept_q, 2'h0, pc_region_q},
                                                  gpr_addr_q);
        end
        rsp_d.arready = !rsp_d.rvalid;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_q <= '0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            rsp_q <= rsp_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
        end
    end

    // ==========================================================
    // Arithmetic and flag update
    assign exec = wr_fire && aw_addr_d == csfl_pkg::OFF_OP && w_strb_d[0];
    assign op = csfl_pkg::csfl_op_e'(w_data_d[2:0]);
    assign wide = w_data_d[csfl_pkg::OP_WIDE_BIT];

    always_comb begin
        logic [15:0] a, t, r;
        logic [16:0] s;
        logic am, tm, rm;
        a = wide ? acc_q : {8'h00, acc_q[7:0]}; // RL10
        t = wide ? tmp_q : {8'h00, tmp_q[7:0]}; // RL11
        s = 17'h0_0000;
        r = a;
        ccr_d = psw_q[7:0];
        am = wide ? a[15] : a[7];
        tm = wide ? t[15] : t[7];
        rm = 1'b0;
        unique case (op)
            csfl_pkg::CSFL_OP_ADD, csfl_pkg::CSFL_OP_SUB: begin
                s = (op == csfl_pkg::CSFL_OP_ADD) ? {1'b0, a} + {1'b0, t} : {1'b0, a} - {1'b0, t};
                r = s[15:0];
                rm = wide ? r[15] : r[7];
                ccr_d[csfl_pkg::CCR_H] = a[4] ^ t[4] ^ s[4]; // RL1
                ccr_d[csfl_pkg::CCR_C] = wide ? s[16] : a[8] ^ t[8] ^ s[8]; // RL7
                ccr_d[csfl_pkg::CCR_V] = (op == csfl_pkg::CSFL_OP_ADD) ? // RL6
                    (am == tm) && (rm != am) : (am != tm) && (rm != am);
            end
            csfl_pkg::CSFL_OP_AND: r = a & t;
            csfl_pkg::CSFL_OP_SHL: begin
                r = {a[14:0], 1'b0};
                ccr_d[csfl_pkg::CCR_C] = am; // RL7
            end
            csfl_pkg::CSFL_OP_SHR: begin
                r = {1'b0, a[15:1]};
                ccr_d[csfl_pkg::CCR_C] = a[0]; // RL7
            end
            default: r = a;
        endcase
        ccr_d[csfl_pkg::CCR_N] = wide ? r[15] : r[7]; // RL4
        ccr_d[csfl_pkg::CCR_Z] = wide ? (r == 16'h0000) : (r[7:0] == 8'h00); // RL5
        acc_d = wide ? r : {acc_q[15:8], r[7:0]}; // RL10
    end

    // ==========================================================
    // Dedicated registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_q <= csfl_pkg::REG16_RESET;
            acc_q <= csfl_pkg::REG16_RESET;
            tmp_q <= csfl_pkg::REG16_RESET;
            idx_q <= csfl_pkg::REG16_RESET;
            ext_q <= csfl_pkg::REG16_RESET;
            stk_q <= csfl_pkg::REG16_RESET;
            psw_q <= csfl_pkg::PSW_RESET; // RL2
            gsel_q <= 3'h0;
        end else if (exec && op <= csfl_pkg::CSFL_OP_SHR) begin
            acc_q <= acc_d;
            psw_q[7:0] <= ccr_d;
        end else if (wr_fire) begin
            unique case (aw_addr_d)
                csfl_pkg::OFF_PC: pc_q <= merge16(pc_q, w_data_d, w_strb_d); // RL12
                csfl_pkg::OFF_ACC: acc_q <= merge16(acc_q, w_data_d, w_strb_d);
                csfl_pkg::OFF_TMP: tmp_q <= merge16(tmp_q, w_data_d, w_strb_d);
                csfl_pkg::OFF_IDX: idx_q <= merge16(idx_q, w_data_d, w_strb_d);
                csfl_pkg::OFF_EXT: ext_q <= merge16(ext_q, w_data_d, w_strb_d);
                csfl_pkg::OFF_STK: stk_q <= merge16(stk_q, w_data_d, w_strb_d);
                csfl_pkg::OFF_PSW: psw_q <= merge16(psw_q, w_data_d, w_strb_d); // RL8
                csfl_pkg::OFF_GSEL: gsel_q <= w_strb_d[0] ? w_data_d[2:0] : gsel_q;
                default: gsel_q <= gsel_q;
            endcase
        end
    end

    // ==========================================================
    // Bank address, memory region and interrupt gate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpr_addr_q <= GPR_BASE;
            pc_region_q <= csfl_pkg::REGION_IO;
        end else begin
            gpr_addr_q <= GPR_BASE + {5'h00, psw_q[15:8], gsel_q}; // RL9 RL14
            pc_region_q <= region_of(pc_q); // RL13
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_accept_q <= 1'b0;
        end else begin
            irq_accept_q <= irq_req && psw_q[csfl_pkg::CCR_I] && // RL2
                            (irq_level < psw_q[csfl_pkg::CCR_IL +: 2]); // RL3
        end
    end

    assign axi_rsp = rsp_q;
    assign irq_accept = irq_accept_q;
    assign psw = psw_q;
    assign gpr_addr = gpr_addr_q;
    assign pc_region = pc_region_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking

    a_ie_reset: assert property ( // RL2
        !rst_n |=> !psw_q[csfl_pkg::CCR_I]) else $error("enable flag not cleared by reset");
    a_irq_blocked: assert property ( // RL2
        disable iff (!rst_n) irq_req && !psw_q[csfl_pkg::CCR_I] |=> !irq_accept_q)
        else $error("interrupt accepted while disabled");
    a_irq_level: assert property ( // RL3
        disable iff (!rst_n) irq_req && psw_q[csfl_pkg::CCR_I]
        |=> irq_accept_q == ($past(irq_level) < $past(psw_q[5:4])))
        else $error("interrupt level gate wrong");
    a_half_add: assert property ( // RL1
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_ADD && !wide
        |=> psw_q[csfl_pkg::CCR_H] == ((5'($past(acc_q[3:0])) + 5'($past(tmp_q[3:0]))) > 5'h0F))
        else $error("half carry wrong");
    a_carry_add: assert property ( // RL7
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_ADD && !wide
        |=> psw_q[csfl_pkg::CCR_C] == ((9'($past(acc_q[7:0])) + 9'($past(tmp_q[7:0]))) > 9'h0FF))
        else $error("carry wrong");
    a_ovf_add: assert property ( // RL6
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_ADD && !wide
        |=> psw_q[csfl_pkg::CCR_V] == (($past(acc_q[7]) == $past(tmp_q[7]))
            && (acc_q[7] != $past(acc_q[7])))) else $error("overflow wrong");
    a_neg_zero: assert property ( // RL4 RL5
        disable iff (!rst_n) exec && op <= csfl_pkg::CSFL_OP_SHR && !wide
        |=> psw_q[csfl_pkg::CCR_N] == acc_q[7] && psw_q[csfl_pkg::CCR_Z] == (acc_q[7:0] == 8'h00))
        else $error("negative or zero flag wrong");
    a_upper_keep: assert property ( // RL10
        disable iff (!rst_n) exec && !wide |=> $stable(acc_q[15:8]))
        else $error("byte operation touched upper accumulator");
    a_shl_carry: assert property ( // RL7
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_SHL && !wide
        |=> psw_q[csfl_pkg::CCR_C] == $past(acc_q[7])) else $error("shift carry wrong");
    a_bank_addr: assert property ( // RL9
        disable iff (!rst_n) ##1
        gpr_addr_q == GPR_BASE + {5'h00, $past(psw_q[15:8]), $past(gsel_q)})
        else $error("bank register address wrong");
    a_bresp_hold: assert property (
        disable iff (!rst_n) rsp_q.bvalid && !axi_req.bready |=> rsp_q.bvalid)
        else $error("write response dropped");
    a_half_sub: assert property ( // RL1
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_SUB && !wide
        |=> psw_q[csfl_pkg::CCR_H] == ($past(acc_q[3:0]) < $past(tmp_q[3:0])))
        else $error("half borrow wrong");
    a_carry_sub: assert property ( // RL7
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_SUB && !wide
        |=> psw_q[csfl_pkg::CCR_C] == ($past(acc_q[7:0]) < $past(tmp_q[7:0])))
        else $error("borrow wrong");
    a_ovf_sub: assert property ( // RL6
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_SUB && !wide
        |=> psw_q[csfl_pkg::CCR_V] == (($past(acc_q[7]) != $past(tmp_q[7]))
            && (acc_q[7] != $past(acc_q[7])))) else $error("subtract overflow wrong");
    a_shr_carry: assert property ( // RL7
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_SHR
        |=> psw_q[csfl_pkg::CCR_C] == $past(acc_q[0])) else $error("right shift carry wrong");
    a_carry_wide: assert property ( // RL7
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_ADD && wide
        |=> psw_q[csfl_pkg::CCR_C] == ((17'($past(acc_q)) + 17'($past(tmp_q))) > 17'h0_FFFF))
        else $error("wide carry wrong");
    a_nz_wide: assert property ( // RL4 RL5
        disable iff (!rst_n) exec && op <= csfl_pkg::CSFL_OP_SHR && wide
        |=> psw_q[csfl_pkg::CCR_N] == acc_q[15] && psw_q[csfl_pkg::CCR_Z] == (acc_q == 16'h0000))
        else $error("wide negative or zero flag wrong");
    a_and_wide: assert property ( // RL10 RL11
        disable iff (!rst_n) exec && op == csfl_pkg::CSFL_OP_AND && wide
        |=> acc_q == ($past(acc_q) & $past(tmp_q))) else $error("wide and result wrong");
    a_tmp_keep: assert property ( // RL11
        disable iff (!rst_n) exec |=> $stable(tmp_q)) else $error("operand register changed");
    a_psw_reset: assert property ( // RL8
        !rst_n |=> psw_q == csfl_pkg::PSW_RESET) else $error("status word reset wrong");
    a_irq_reset: assert property ( // RL2
        !rst_n |=> !irq_accept_q) else $error("interrupt accepted in reset");
    a_region_io: assert property ( // RL13
        disable iff (!rst_n) pc_q <= IO_TOP |=> pc_region_q == csfl_pkg::REGION_IO)
        else $error("low region wrong");
    a_region_vec: assert property ( // RL13
        disable iff (!rst_n) pc_q >= VEC_BASE |=> pc_region_q == csfl_pkg::REGION_VEC)
        else $error("vector region wrong");
    a_rdata_hold: assert property (
        disable iff (!rst_n) rsp_q.rvalid && !axi_req.rready
        |=> rsp_q.rvalid && $stable(rsp_q.rdata)) else $error("read answer dropped");

endmodule : csfl_core

//--- rtl/csfl_pkg.sv
// Contract
// (RL1) Half carry marks carry or borrow bit3->bit4
// (RL2) Interrupts accepted only while enable flag set
// (RL3) Request level must outrank the level mask
// (RL4) Negative flag copies result most significant bit
// (RL5) Zero flag set exactly when result is zero
// (RL6) Overflow flag marks two's-complement overflow
// (RL7) Carry from bit 7; shifts load shifted-out bit; the code's wide add/sub take carry from bit 15
// (RL8) Status word: bank pointer high, condition code low
// (RL9) Eight-bit banked registers, eight per bank, 32 banks; the code takes the bank from all 8 bits psw[15:8], giving 256 banks
// (RL10) Accumulator 16 bits; byte ops use low byte
// (RL11) Temporary accumulator is 16-bit second operand
// (RL12) Counter, index, extra and stack pointers 16 bits
// (RL13) 64K space: I/O, data, program, vectors on top
// (RL14) Banked register address from configurable mapping
package csfl_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_PC = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_TMP = 8'h08;
    localparam logic [7:0] OFF_IDX = 8'h0C;
    localparam logic [7:0] OFF_EXT = 8'h10;
    localparam logic [7:0] OFF_STK = 8'h14;
    localparam logic [7:0] OFF_PSW = 8'h18;
    localparam logic [7:0] OFF_OP = 8'h1C;
    localparam logic [7:0] OFF_STAT = 8'h20;
    localparam logic [7:0] OFF_GSEL = 8'h24;

    // ==========================================================
    // Condition code fields
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam int CCR_IL = 4;
    localparam int CCR_I = 6;
    localparam int CCR_H = 7;
    localparam int OP_WIDE_BIT = 4;
    localparam logic [15:0] PSW_RESET = 16'h0030;
    localparam logic [15:0] REG16_RESET = 16'h0000;

    // ==========================================================
    // Bus answers and memory regions
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] REGION_IO = 2'h0;
    localparam logic [1:0] REGION_DATA = 2'h1;
    localparam logic [1:0] REGION_PROG = 2'h2;
    localparam logic [1:0] REGION_VEC = 2'h3;

    typedef enum logic [2:0] {
        CSFL_OP_ADD = 3'h0,
        CSFL_OP_SUB = 3'h1,
        CSFL_OP_AND = 3'h2,
        CSFL_OP_SHL = 3'h3,
        CSFL_OP_SHR = 3'h4
    } csfl_op_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } csfl_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csfl_axi_rsp_s;

endpackage : csfl_pkg

//--- tb/tb_cpu_status_and_flag_logic.sv
`timescale 1ns/1ps
module tb_cpu_status_and_flag_logic;
    // ==========================================================
    // Signals and design
    logic clk;
    logic rst_n;
    csfl_pkg::csfl_axi_req_s axi_req;
    csfl_pkg::csfl_axi_rsp_s axi_rsp;
    logic irq_req;
    logic [1:0] irq_level;
    logic irq_accept;
    logic [15:0] psw;
    logic [15:0] gpr_addr;
    logic [1:0] pc_region;
    logic [1:0] bresp_seen;
    int failures;
    int n_compared;
    int seed;
    csfl_core dut_u (.clk(clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .irq_req(irq_req), .irq_level(irq_level), .irq_accept(irq_accept), .psw(psw),
        .gpr_addr(gpr_addr), .pc_region(pc_region));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Bus tasks and checks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!(axi_rsp.bvalid && axi_req.bready));
        bresp_seen = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!(axi_rsp.rvalid && axi_req.rready));
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rd
    task automatic irq_try(input logic [1:0] lvl, input logic exp);
        @(posedge clk);
        irq_req <= 1'b1;
        irq_level <= lvl;
        @(posedge clk);
        @(posedge clk);
        chk("irq_accept", {31'h0, exp}, {31'h0, irq_accept});
        irq_req <= 1'b0;
    endtask : irq_try
    // ==========================================================
    // Expected ALU result: {acc, ccr}
    function automatic logic [23:0] alu(input logic [15:0] a, input logic [15:0] t,
        input logic [2:0] op, input logic w, input logic [7:0] c);
        logic [16:0] sa, st, r;
        logic [4:0] h;
        logic cy, ma, mt, mr;
        sa = w ? {1'b0, a} : {9'h0, a[7:0]};
        st = w ? {1'b0, t} : {9'h0, t[7:0]};
        h = (op == 3'h1) ? {1'b0, sa[3:0]} - {1'b0, st[3:0]} : {1'b0, sa[3:0]} + {1'b0, st[3:0]};
        case (op)
            3'h0: r = sa + st;
            3'h1: r = sa - st;
            3'h2: r = sa & st;
            3'h3: r = sa << 1;
            default: r = sa >> 1;
        endcase
        cy = w ? r[16] : r[8];
        ma = w ? sa[15] : sa[7];
        mt = w ? st[15] : st[7];
        mr = w ? r[15] : r[7];
        if (op <= 3'h1) begin
            c[csfl_pkg::CCR_H] = h[4];
            c[csfl_pkg::CCR_C] = cy;
            c[csfl_pkg::CCR_V] = (op == 3'h0) ? (ma == mt && mr != ma) : (ma != mt && mr != ma);
        end
        if (op == 3'h3) c[csfl_pkg::CCR_C] = ma;
        if (op == 3'h4) c[csfl_pkg::CCR_C] = sa[0];
        c[csfl_pkg::CCR_N] = mr;
        c[csfl_pkg::CCR_Z] = w ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
        return {w ? r[15:0] : {a[15:8], r[7:0]}, c};
    endfunction : alu
    // ==========================================================
    // Main sequence
    logic [31:0] d;
    logic [1:0] rsp;
    logic [15:0] a, t, pcv[6];
    logic [2:0] op, num;
    logic [7:0] c;
    logic [4:0] bank;
    logic w;
    logic [23:0] e;
    initial begin
        seed = 83;
        failures = 0;
        n_compared = 0;
        axi_req = '0;
        irq_req = 1'b0;
        irq_level = 2'h0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(csfl_pkg::OFF_PSW, d, rsp);
        chk("psw reset", 32'h0000_0030, d);
        rd(csfl_pkg::OFF_ACC, d, rsp);
        chk("acc reset", 32'h0000_0000, d);
        chk("gpr reset", 32'h0000_0100, {16'h0, gpr_addr});
        irq_try(2'h0, 1'b0);
        wr(csfl_pkg::OFF_PSW, 32'h0000_0060);
        irq_try(2'h1, 1'b1);
        irq_try(2'h2, 1'b0);
        wr(csfl_pkg::OFF_PSW, 32'h0000_0040);
        irq_try(2'h0, 1'b0);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk("psw after reset", {16'h0, csfl_pkg::PSW_RESET}, {16'h0, psw});
        irq_try(2'h0, 1'b0);
        $display("test reset and interrupt gate done");
        for (int i = 0; i < 40; i++) begin
            a = $random(seed);
            t = $random(seed);
            op = 3'($unsigned($random(seed)) % 5);
            w = $random(seed);
            c = $random(seed);
            if (i < 4) begin
                a = (i < 2) ? 16'h807F : 16'h8000;
                t = (i == 0) ? 16'h0001 : ((i == 1) ? 16'h0081 : 16'h8000);
                op = (i == 2) ? 3'h1 : 3'h0;
                w = (i == 3);
            end
            wr(csfl_pkg::OFF_ACC, {16'hA5A5, a});
            wr(csfl_pkg::OFF_TMP, {16'h0, t});
            wr(csfl_pkg::OFF_PSW, {24'h0, c});
            wr(csfl_pkg::OFF_OP, {27'h0, w, 1'b0, op});
            e = alu(a, t, op, w, c);
            rd(csfl_pkg::OFF_ACC, d, rsp);
            chk("acc result", {16'h0, e[23:8]}, d);
            rd(csfl_pkg::OFF_PSW, d, rsp);
            chk("ccr flags", {24'h0, e[7:0]}, d);
        end
        wr(csfl_pkg::OFF_ACC, 32'h0000_1234);
        wr(csfl_pkg::OFF_OP, 32'h0000_0017);
        rd(csfl_pkg::OFF_ACC, d, rsp);
        chk("acc after bad op", 32'h0000_1234, d);
        $display("test alu flags done");
        for (int i = 0; i < 8; i++) begin
            bank = (i == 0) ? 5'h1F : 5'($random(seed));
            num = (i == 0) ? 3'h7 : 3'($random(seed));
            wr(csfl_pkg::OFF_PSW, {16'h0, 3'h0, bank, 8'h30});
            wr(csfl_pkg::OFF_GSEL, {29'h0, num});
            chk("psw port", {16'h0, 3'h0, bank, 8'h30}, {16'h0, psw});
            rd(csfl_pkg::OFF_GSEL, d, rsp);
            chk("gpr addr", {16'h0, 16'h0100 + {8'h0, bank, 3'h0} + {13'h0, num}}, d);
        end
        $display("test register banks done");
        pcv = '{16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFBF, 16'hFFC0};
        for (int i = 0; i < 6; i++) begin
            wr(csfl_pkg::OFF_PC, {16'hFFFF, pcv[i]});
            rd(csfl_pkg::OFF_PC, d, rsp);
            chk("pc value", {16'h0, pcv[i]}, d);
            rd(csfl_pkg::OFF_STAT, d, rsp);
            chk("pc region", 32'((i + 1) / 2), {30'h0, d[1:0]});
            chk("region port", 32'((i + 1) / 2), {30'h0, pc_region});
        end
        wr(csfl_pkg::OFF_IDX, 32'hABCD_1234);
        rd(csfl_pkg::OFF_IDX, d, rsp);
        chk("index reg", 32'h0000_1234, d);
        wr(csfl_pkg::OFF_EXT, 32'h0000_FEDC);
        rd(csfl_pkg::OFF_EXT, d, rsp);
        chk("extra ptr", 32'h0000_FEDC, d);
        wr(csfl_pkg::OFF_STK, 32'h0000_8001);
        chk("write bresp", {30'h0, csfl_pkg::RESP_OKAY}, {30'h0, bresp_seen});
        rd(csfl_pkg::OFF_STK, d, rsp);
        chk("stack ptr", 32'h0000_8001, d);
        chk("read resp", {30'h0, csfl_pkg::RESP_OKAY}, {30'h0, rsp});
        rd(8'h28, d, rsp);
        chk("unmapped resp", {30'h0, csfl_pkg::RESP_SLVERR}, {30'h0, rsp});
        chk("unmapped data", 32'h0000_0000, d);
        wr(8'h06, 32'h0000_FFFF);
        chk("unaligned bresp", {30'h0, csfl_pkg::RESP_SLVERR}, {30'h0, bresp_seen});
        rd(csfl_pkg::OFF_STK, d, rsp);
        chk("stack after bad write", 32'h0000_8001, d);
        $display("test pointers and map done");
        give_verdict();
    end
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule : tb_cpu_status_and_flag_logic
